// File: pkg/ppfc_pkg.sv
// Package for the packet flow and pause control block.
// Assumes a single 40 MHz clock domain and byte-wide data paths.
package ppfc_pkg;
  // ----------------------------------------
  // Register map (word index = byte address)
  // ----------------------------------------
  localparam logic [3:0] REG_RX_CTRL = 4'h0;
  localparam logic [3:0] REG_FRAME_TYPE = 4'h1;
  localparam logic [3:0] REG_TIMER_VALUE = 4'h2;
  localparam logic [3:0] REG_REFRESH = 4'h3;
  localparam logic [3:0] REG_HIGH_THR = 4'h4;
  localparam logic [3:0] REG_LOW_THR = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_STATION_LO = 4'h7;
  localparam logic [3:0] REG_STATION_HI = 4'h8;
  localparam int RX_PAUSE_EN_BIT = 7;
  localparam int TX_PAUSE_EN_BIT = 6;
  // ----------------------------------------
  // Frame constants
  // ----------------------------------------
  localparam logic [47:0] CTRL_MCAST_ADDR = 48'h0180C2000001;
  localparam logic [15:0] PAUSE_ETHERTYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam int SLOT_BYTES = 64;
  localparam int TX_START_BYTES = 8;
  localparam int MAX_RETRIES = 16;
  localparam int BUF_BYTES = 3072;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_MHZ = 40;
  localparam int K1_RECOVERY_US = 10;
  localparam int K1_RECOVERY_CYC = K1_RECOVERY_US * CLOCK_MHZ;
  // Nanoseconds per byte time at 1000/100/10 Mb/s (8 ns, 80 ns, 800 ns)
  localparam int BYTE_NS_1G = 8;
  localparam int BYTE_NS_100M = 80;
  localparam int BYTE_NS_10M = 800;
  localparam int CLK_NS = 1000 / CLOCK_MHZ;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} ppfc_speed_t;
  // In-band status toward the controller
  typedef struct packed {
    logic valid;
    logic txOff;
  } ppfc_status_t;
  // Received frame header summary
  typedef struct packed {
    logic [47:0] dest;
    logic [15:0] etherType;
    logic [15:0] opcode;
    logic [15:0] timer;
  } ppfc_hdr_t;
endpackage : ppfc_pkg

// File: rtl/ppfc_flow_ctrl.sv
// Packet path gating and pause flow control of a network connection device.
// Assumes byte strobes from controller link and wire MAC, all on clock.
`timescale 1ns/1ps
`default_nettype none
module ppfc_flow_ctrl
  import ppfc_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_BYTES,
  parameter int K1_CYC = K1_RECOVERY_CYC
)(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  input wire logic pcieActive,
  input wire logic k1State,
  input wire ppfc_speed_t linkSpeed,
  input wire logic halfDuplex,
  input wire logic txByteIn,
  input wire logic txPktEnd,
  input wire logic ctrlMsgValid,
  input wire logic ctrlPauseReq,
  input wire logic ctrlXonReq,
  input wire logic wireTxDone,
  input wire logic collision,
  input wire logic [4:0] retryCount,
  input wire logic rxActive,
  input wire logic rxByteIn,
  input wire logic rxPktEnd,
  input wire ppfc_hdr_t rxHdr,
  input wire logic rxHdrValid,
  input wire logic fwdDone,
  output logic txStart,
  output logic txHalted,
  output logic txInReady,
  output logic k1Wake,
  output logic fwdStart,
  output logic rxDrop,
  output ppfc_status_t statusMsg,
  output logic pauseSend,
  output logic [15:0] pauseTimerOut
);
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam int BYTE_CYC_1G = (BYTE_NS_1G + CLK_NS - 1) / CLK_NS;
  localparam int SLOT_CYC_100 = SLOT_BYTES * BYTE_NS_100M / CLK_NS;
  localparam int SLOT_CYC_10 = SLOT_BYTES * BYTE_NS_10M / CLK_NS;
  localparam int SLOT_CYC_1G = SLOT_BYTES * BYTE_CYC_1G;
  initial if (BUF_DEPTH < TX_START_BYTES || K1_CYC < 1) $error("bad parameters");
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic rxPauseEn_r, txPauseEn_r;
  logic [15:0] frameType_r, timerValue_r, refresh_r;
  logic [CW-1:0] highThr_r, lowThr_r;
  logic [47:0] station_r;
  logic [15:0] pauseTimer_r;
  logic [15:0] slotCnt_r;
  logic pausedFlow_r, txOff_r, txOffPending_r, rxInPkt_r, inFwd_r;
  logic [CW-1:0] txLevel_r, rxLevel_r;
  logic [15:0] refreshCnt_r;
  logic smbXoffSent_r;
  logic [15:0] k1Cnt_r;
  logic k1Wait_r;
  // Register writes
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      rxPauseEn_r <= 1'b0;
      txPauseEn_r <= 1'b0;
      frameType_r <= 16'h0000;
      timerValue_r <= 16'h0000;
      refresh_r <= 16'h0000;
      highThr_r <= '0;
      lowThr_r <= '0;
      station_r <= 48'h000000000000;
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        REG_RX_CTRL:
        begin
          rxPauseEn_r <= regWrData[RX_PAUSE_EN_BIT];
          txPauseEn_r <= regWrData[TX_PAUSE_EN_BIT];
        end
        REG_FRAME_TYPE: frameType_r <= regWrData[15:0];
        REG_TIMER_VALUE: timerValue_r <= regWrData[15:0];
        REG_REFRESH: refresh_r <= regWrData[15:0];
        REG_HIGH_THR: highThr_r <= regWrData[CW-1:0];
        REG_LOW_THR: lowThr_r <= regWrData[CW-1:0];
        REG_STATION_LO: station_r[31:0] <= regWrData;
        REG_STATION_HI: station_r[47:32] <= regWrData[15:0];
        default: ;
      endcase
    end
  // Read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      regRdData <= 32'h00000000;
    else if (regRead)
    begin
      unique case (regAddr)
        REG_RX_CTRL: regRdData <= 32'(rxPauseEn_r) << RX_PAUSE_EN_BIT
          | 32'(txPauseEn_r) << TX_PAUSE_EN_BIT;
        REG_FRAME_TYPE: regRdData <= {16'h0000, frameType_r};
        REG_TIMER_VALUE: regRdData <= {16'h0000, timerValue_r};
        REG_REFRESH: regRdData <= {16'h0000, refresh_r};
        REG_HIGH_THR: regRdData <= 32'(highThr_r);
        REG_LOW_THR: regRdData <= 32'(lowThr_r);
        REG_STATUS: regRdData <= {16'h0000, pauseTimer_r} | 32'(pausedFlow_r) << 16
          | 32'(txOff_r) << 17;
        REG_STATION_LO: regRdData <= station_r[31:0];
        REG_STATION_HI: regRdData <= {16'h0000, station_r[47:32]};
        default: regRdData <= 32'h00000000;
      endcase
    end
    else
      regRdData <= 32'h00000000;
  // ----------------------------------------
  // Pause frame reception
  // ----------------------------------------
  logic addrOk, pauseValid, isXoff, isXon;
  assign addrOk = rxHdr.dest == CTRL_MCAST_ADDR || rxHdr.dest == station_r;
  assign pauseValid = rxHdrValid && rxPauseEn_r && addrOk
    && rxHdr.etherType == PAUSE_ETHERTYPE && rxHdr.opcode == PAUSE_OPCODE;
  assign isXoff = pauseValid && rxHdr.timer != 16'h0000;
  assign isXon = pauseValid && rxHdr.timer == 16'h0000;
  logic [15:0] slotLen;
  always_comb
  begin
    unique case (linkSpeed)
      SPD_1000: slotLen = 16'(SLOT_CYC_1G);
      SPD_100: slotLen = 16'(SLOT_CYC_100);
      default: slotLen = 16'(SLOT_CYC_10);
    endcase
  end
  // Pause timer: loaded by XOFF, one count per slot time
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      pauseTimer_r <= 16'h0000;
      slotCnt_r <= 16'h0000;
      pausedFlow_r <= 1'b0;
    end
    else if (isXoff)
    begin
      pauseTimer_r <= rxHdr.timer;
      slotCnt_r <= 16'h0000;
      pausedFlow_r <= 1'b1;
    end
    else if (isXon)
    begin
      pauseTimer_r <= 16'h0000;
      pausedFlow_r <= 1'b0;
    end
    else if (pausedFlow_r)
    begin
      if (slotCnt_r + 16'h0001 >= slotLen)
      begin
        slotCnt_r <= 16'h0000;
        pauseTimer_r <= pauseTimer_r - 16'h0001;
        if (pauseTimer_r == 16'h0001)
          pausedFlow_r <= 1'b0;
      end
      else
        slotCnt_r <= slotCnt_r + 16'h0001;
    end
  // ----------------------------------------
  // Transmit gating
  // ----------------------------------------
  logic haltNow, collHold_r;
  assign haltNow = pausedFlow_r || (halfDuplex && rxActive) || collHold_r;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      collHold_r <= 1'b0;
    else if (halfDuplex && collision)
      collHold_r <= 1'b1;
    else if (wireTxDone || retryCount >= 5'(MAX_RETRIES))
      collHold_r <= 1'b0;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      txHalted <= 1'b0;
    else
      txHalted <= haltNow;
  // Tx buffer level; data keeps flowing in while the wire is halted
  logic txPop;
  assign txPop = txStart && !haltNow && txLevel_r != '0;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      txLevel_r <= '0;
    else if (txByteIn && txInReady && !txPop)
      txLevel_r <= txLevel_r + CW'(1);
    else if (txPop && !(txByteIn && txInReady))
      txLevel_r <= txLevel_r - CW'(1);
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      txInReady <= 1'b0;
    else
      txInReady <= txLevel_r < CW'(BUF_DEPTH - 1);
  // Start threshold: 8 bytes over PCIe, whole packet over SMBus
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      txStart <= 1'b0;
    else if (wireTxDone)
      txStart <= 1'b0;
    else if (!haltNow && (pcieActive ? txLevel_r >= CW'(TX_START_BYTES) : txPktEnd))
      txStart <= 1'b1;
  // ----------------------------------------
  // In-band status toward the controller
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      rxInPkt_r <= 1'b0;
    else if (rxByteIn)
      rxInPkt_r <= 1'b1;
    else if (rxPktEnd)
      rxInPkt_r <= 1'b0;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      txOff_r <= 1'b0;
      txOffPending_r <= 1'b0;
      statusMsg <= '0;
    end
    else
    begin
      statusMsg.valid <= 1'b0;
      if (haltNow != txOff_r)
        txOffPending_r <= 1'b1;
      // Only in a gap; a change already undone is simply dropped
      if (txOffPending_r && !rxInPkt_r && !inFwd_r)
      begin
        txOffPending_r <= 1'b0;
        if (haltNow != txOff_r)
        begin
          txOff_r <= haltNow;
          statusMsg.valid <= 1'b1;
          statusMsg.txOff <= haltNow;
        end
      end
    end
  // ----------------------------------------
  // Receive path, K1 recovery and forwarding
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      rxLevel_r <= '0;
    else if (rxByteIn && !rxDrop && rxLevel_r < CW'(BUF_DEPTH))
      rxLevel_r <= rxLevel_r + CW'(1);
    else if (fwdDone || rxDrop)
      rxLevel_r <= '0;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      k1Wake <= 1'b0;
      k1Wait_r <= 1'b0;
      k1Cnt_r <= 16'h0000;
      rxDrop <= 1'b0;
    end
    else
    begin
      if (rxByteIn && !rxInPkt_r && pcieActive && k1State)
      begin
        k1Wake <= 1'b1;
        k1Wait_r <= 1'b1;
        k1Cnt_r <= 16'h0000;
      end
      else if (k1Wait_r && !k1State)
      begin
        k1Wake <= 1'b0;
        k1Wait_r <= 1'b0;
      end
      else if (k1Wait_r)
      begin
        k1Cnt_r <= k1Cnt_r + 16'h0001;
        if (k1Cnt_r >= 16'(K1_CYC - 1))
        begin
          rxDrop <= 1'b1;
          k1Wait_r <= 1'b0;
          k1Wake <= 1'b0;
        end
      end
      if (rxPktEnd)
        rxDrop <= 1'b0;
    end
  // Forward at 1G once link is up, otherwise after whole packet
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      fwdStart <= 1'b0;
      inFwd_r <= 1'b0;
    end
    else
    begin
      fwdStart <= 1'b0;
      if (fwdDone)
        inFwd_r <= 1'b0;
      else if (!inFwd_r && rxLevel_r != '0 && !rxDrop && !k1Wait_r && !k1State
               && (linkSpeed == SPD_1000 || rxPktEnd))
      begin
        fwdStart <= 1'b1;
        inFwd_r <= 1'b1;
      end
    end
  // ----------------------------------------
  // Pause frame generation
  // ----------------------------------------
  logic [CW:0] fill;
  logic ctrlReqOk;
  assign fill = {1'b0, txLevel_r} + {1'b0, rxLevel_r};
  assign ctrlReqOk = ctrlMsgValid && !rxInPkt_r;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      pauseSend <= 1'b0;
      pauseTimerOut <= 16'h0000;
      smbXoffSent_r <= 1'b0;
      refreshCnt_r <= 16'h0000;
    end
    else
    begin
      pauseSend <= 1'b0;
      if (pcieActive)
      begin
        smbXoffSent_r <= 1'b0;
        if (ctrlReqOk && (ctrlPauseReq || ctrlXonReq))
        begin
          pauseSend <= 1'b1;
          pauseTimerOut <= ctrlPauseReq ? timerValue_r : 16'h0000;
        end
      end
      else if (txPauseEn_r)
      begin
        if (smbXoffSent_r)
          refreshCnt_r <= refreshCnt_r + 16'h0001;
        if (!smbXoffSent_r && fill > {1'b0, highThr_r})
        begin
          pauseSend <= 1'b1;
          pauseTimerOut <= timerValue_r;
          smbXoffSent_r <= 1'b1;
          refreshCnt_r <= 16'h0000;
        end
        else if (smbXoffSent_r && fill < {1'b0, lowThr_r})
        begin
          pauseSend <= 1'b1;
          pauseTimerOut <= 16'h0000;
          smbXoffSent_r <= 1'b0;
        end
        else if (smbXoffSent_r && refreshCnt_r >= refresh_r)
        begin
          pauseSend <= 1'b1;
          pauseTimerOut <= timerValue_r;
          refreshCnt_r <= 16'h0000;
        end
      end
    end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  xoff_load_a: assert property (@(posedge clock) disable iff (!rst_b)
    isXoff |=> pauseTimer_r == $past(rxHdr.timer) && pausedFlow_r)
    else $error("xoff did not load pause timer");
  xon_resume_a: assert property (@(posedge clock) disable iff (!rst_b)
    isXon |=> !pausedFlow_r)
    else $error("xon did not release pause");
  pause_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
    (rxHdrValid && !rxPauseEn_r && !pausedFlow_r) |=> !pausedFlow_r)
    else $error("pause acted while disabled");
  halt_out_a: assert property (@(posedge clock) disable iff (!rst_b)
    pausedFlow_r |=> txHalted)
    else $error("tx not halted while paused");
  status_gap_a: assert property (@(posedge clock) disable iff (!rst_b)
    statusMsg.valid |-> !$past(rxInPkt_r))
    else $error("status sent inside a packet");
  pcie_pause_a: assert property (@(posedge clock) disable iff (!rst_b)
    (pcieActive && ctrlReqOk && ctrlPauseReq) |=> pauseSend
      && pauseTimerOut == $past(timerValue_r))
    else $error("pause frame not sent on request");
  midpkt_msg_a: assert property (@(posedge clock) disable iff (!rst_b)
    (pcieActive && ctrlMsgValid && rxInPkt_r) |=> !pauseSend)
    else $error("message accepted mid packet");
  k1_drop_a: assert property (@(posedge clock) disable iff (!rst_b)
    (k1Wait_r && k1State && k1Cnt_r == 16'(K1_CYC - 1) && !rxPktEnd) |=> rxDrop)
    else $error("slow recovery did not drop packet");
endmodule : ppfc_flow_ctrl
`default_nettype wire

// File: verification/ppfc_ctrl_model.sv
// Controller-side model: upstream Tx bytes and in-band pause requests.
// Assumes the bench calls its tasks; drives right after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ppfc_ctrl_model
  import ppfc_pkg::*;
(
  input wire logic clock,
  input wire logic txInReady,
  output logic txByteIn,
  output logic txPktEnd,
  output logic ctrlMsgValid,
  output logic ctrlPauseReq,
  output logic ctrlXonReq
);
  logic txPauseEn;
  logic inPacket;
  // Idle levels
  initial
  begin
    txByteIn = 1'b0;
    txPktEnd = 1'b0;
    ctrlMsgValid = 1'b0;
    ctrlPauseReq = 1'b0;
    ctrlXonReq = 1'b0;
    txPauseEn = 1'b0;
    inPacket = 1'b0;
  end
  // Byte held until an edge sees ready, so none is lost while halted
  task automatic send_bytes(input int n, input bit last);
    @(posedge clock);
    for (int i = 0; i < n; i++)
    begin
      txByteIn <= 1'b1;
      txPktEnd <= last && (i == n - 1);
      do @(negedge clock); while (txInReady !== 1'b1);
      @(posedge clock);
    end
    txByteIn <= 1'b0;
    txPktEnd <= 1'b0;
    inPacket = !last;
  endtask : send_bytes
  // Requests only between packets and only when software enabled them
  task automatic request(input bit xon);
    if (!txPauseEn || inPacket) return;
    @(posedge clock);
    ctrlMsgValid <= 1'b1;
    ctrlPauseReq <= !xon;
    ctrlXonReq <= xon;
    @(posedge clock);
    ctrlMsgValid <= 1'b0;
    ctrlPauseReq <= 1'b0;
    ctrlXonReq <= 1'b0;
  endtask : request
endmodule : ppfc_ctrl_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the packet flow and pause control block.
// Assumes the controller model drives the upstream Tx side.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ppfc_pkg::*;
  localparam int K1_TEST = 40;
  logic clock, rst_b, regWrite, regRead, pcieActive, k1State, halfDuplex;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData, rdVal;
  ppfc_speed_t linkSpeed;
  logic txByteIn, txPktEnd, ctrlMsgValid, ctrlPauseReq, ctrlXonReq;
  logic wireTxDone, collision, rxActive, rxByteIn, rxPktEnd, rxHdrValid, fwdDone;
  logic [4:0] retryCount;
  ppfc_hdr_t rxHdr;
  logic txStart, txHalted, txInReady, k1Wake, fwdStart, rxDrop, pauseSend, lastOff;
  ppfc_status_t statusMsg;
  logic [15:0] pauseTimerOut, sentTimer;
  int numErrors, numChecks, cycles, sentCount, msgCount, m0;
  ppfc_flow_ctrl #(.K1_CYC(K1_TEST)) ppfc_flow_ctrl_inst (
    .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .pcieActive(pcieActive), .k1State(k1State), .linkSpeed(linkSpeed),
    .halfDuplex(halfDuplex), .txByteIn(txByteIn), .txPktEnd(txPktEnd),
    .ctrlMsgValid(ctrlMsgValid), .ctrlPauseReq(ctrlPauseReq), .ctrlXonReq(ctrlXonReq),
    .wireTxDone(wireTxDone), .collision(collision), .retryCount(retryCount),
    .rxActive(rxActive), .rxByteIn(rxByteIn), .rxPktEnd(rxPktEnd), .rxHdr(rxHdr),
    .rxHdrValid(rxHdrValid), .fwdDone(fwdDone), .txStart(txStart),
    .txHalted(txHalted), .txInReady(txInReady), .k1Wake(k1Wake),
    .fwdStart(fwdStart), .rxDrop(rxDrop), .statusMsg(statusMsg),
    .pauseSend(pauseSend), .pauseTimerOut(pauseTimerOut));
  ppfc_ctrl_model ppfc_ctrl_model_inst (
    .clock(clock), .txInReady(txInReady), .txByteIn(txByteIn), .txPktEnd(txPktEnd),
    .ctrlMsgValid(ctrlMsgValid), .ctrlPauseReq(ctrlPauseReq), .ctrlXonReq(ctrlXonReq));
  // 40 MHz clock
  always #12.5 clock = ~clock;
  // Monitor status messages, sent pause frames and the hang limit
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (statusMsg.valid === 1'b1)
    begin
      lastOff <= statusMsg.txOff;
      msgCount <= msgCount + 1;
    end
    if (pauseSend === 1'b1)
    begin
      sentTimer <= pauseTimerOut;
      sentCount <= sentCount + 1;
    end
    if (cycles == 20000)
    begin
      numErrors++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : reg_wr
  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rdVal = regRdData;
  endtask : reg_rd
  // Bounded wait on a level, sampled mid-cycle
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    for (int n = 0; n < lim && s !== v; n++) @(negedge clock);
  endtask : wait_lvl
  task automatic send_hdr(input logic [47:0] d, input logic [15:0] op, input logic [15:0] t);
    m0 = msgCount;
    @(posedge clock);
    rxHdr <= '{dest: d, etherType: PAUSE_ETHERTYPE, opcode: op, timer: t};
    rxHdrValid <= 1'b1;
    @(posedge clock);
    rxHdrValid <= 1'b0;
  endtask : send_hdr
  task automatic wait_msg();
    for (int n = 0; n < 40 && msgCount == m0; n++) @(negedge clock);
  endtask : wait_msg
  // Let the buffer drain first so the start level does not re-arm
  task automatic tx_done();
    repeat (20) @(negedge clock);
    @(posedge clock);
    wireTxDone <= 1'b1;
    @(posedge clock);
    wireTxDone <= 1'b0;
  endtask : tx_done
  task automatic complete_run();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {clock, rst_b, regWrite, regRead, k1State, halfDuplex, wireTxDone} = '0;
    {collision, rxActive, rxByteIn, rxPktEnd, rxHdrValid, fwdDone} = '0;
    {regAddr, regWrData, retryCount, rxHdr, numErrors, numChecks} = '0;
    {cycles, sentCount, msgCount, lastOff, sentTimer} = '0;
    pcieActive = 1'b1;
    linkSpeed = SPD_1000;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    // Three 16-bit pause values, then an unmapped place
    for (int i = 1; i < 4; i++)
    begin
      reg_wr(4'(i), 32'hFFFFFFFF);
      reg_rd(4'(i));
      check(rdVal, 32'h0000FFFF);
    end
    reg_rd(4'hF);
    check(rdVal, 32'h00000000);
    reg_wr(REG_TIMER_VALUE, 32'h00000005);
    $display("test registers done");
    // PCIe mode starts the wire after the eighth byte
    ppfc_ctrl_model_inst.send_bytes(7, 1'b0);
    repeat (3) @(negedge clock);
    check(txStart, 1'b0);
    ppfc_ctrl_model_inst.send_bytes(5, 1'b1);
    wait_lvl(txStart, 1'b1, 8);
    check(txStart, 1'b1);
    tx_done();
    // SMBus mode waits for the whole packet
    @(posedge clock);
    pcieActive <= 1'b0;
    ppfc_ctrl_model_inst.send_bytes(12, 1'b0);
    repeat (3) @(negedge clock);
    check(txStart, 1'b0);
    ppfc_ctrl_model_inst.send_bytes(1, 1'b1);
    wait_lvl(txStart, 1'b1, 8);
    check(txStart, 1'b1);
    tx_done();
    pcieActive <= 1'b1;
    $display("test tx start done");
    // Frames that must not pause: disabled, bad opcode, foreign address
    reg_wr(REG_STATION_LO, 32'h33445566);
    reg_wr(REG_STATION_HI, 32'h00001122);
    send_hdr(CTRL_MCAST_ADDR, PAUSE_OPCODE, 16'h0004);
    reg_wr(REG_RX_CTRL, 32'h000000C0);
    send_hdr(CTRL_MCAST_ADDR, 16'h0002, 16'h0004);
    send_hdr(48'h112233445567, PAUSE_OPCODE, 16'h0004);
    repeat (4) @(negedge clock);
    check(txHalted, 1'b0);
    // Valid XOFF halts; upstream bytes still taken
    send_hdr(CTRL_MCAST_ADDR, PAUSE_OPCODE, 16'h0100);
    wait_lvl(txHalted, 1'b1, 4);
    check(txHalted, 1'b1);
    wait_msg();
    check(lastOff, 1'b1);
    ppfc_ctrl_model_inst.send_bytes(10, 1'b1);
    check(txInReady, 1'b1);
    check(txStart, 1'b0);
    // XON to the station address resumes
    send_hdr(48'h112233445566, PAUSE_OPCODE, 16'h0000);
    wait_lvl(txHalted, 1'b0, 4);
    check(txHalted, 1'b0);
    wait_msg();
    check(lastOff, 1'b0);
    wait_lvl(txStart, 1'b1, 8);
    check(txStart, 1'b1);
    tx_done();
    // One slot at 1 Gb/s expires on its own
    send_hdr(CTRL_MCAST_ADDR, PAUSE_OPCODE, 16'h0001);
    repeat (20) @(negedge clock);
    check(txHalted, 1'b1);
    wait_lvl(txHalted, 1'b0, 300);
    check(txHalted, 1'b0);
    $display("test pause rx done");
    // In-band requests become pause frames: XOFF with the stored timer, XON with zero
    ppfc_ctrl_model_inst.txPauseEn = 1'b1;
    ppfc_ctrl_model_inst.request(1'b0);
    repeat (3) @(negedge clock);
    check(sentCount, 1);
    check(sentTimer, 16'h0005);
    ppfc_ctrl_model_inst.request(1'b1);
    repeat (3) @(negedge clock);
    check(sentTimer, 16'h0000);
    $display("test pause tx done");
    // Half-duplex collision halts until the retry ends
    reg_wr(REG_RX_CTRL, 32'h00000080);
    @(posedge clock);
    halfDuplex <= 1'b1;
    collision <= 1'b1;
    @(posedge clock);
    collision <= 1'b0;
    wait_lvl(txHalted, 1'b1, 4);
    check(txHalted, 1'b1);
    tx_done();
    wait_lvl(txHalted, 1'b0, 4);
    check(txHalted, 1'b0);
    halfDuplex <= 1'b0;
    // Reception in K1 wakes the link; slow recovery drops the packet
    @(posedge clock);
    k1State <= 1'b1;
    rxActive <= 1'b1;
    rxByteIn <= 1'b1;
    @(posedge clock);
    rxByteIn <= 1'b0;
    wait_lvl(k1Wake, 1'b1, 4);
    check(k1Wake, 1'b1);
    wait_lvl(rxDrop, 1'b1, K1_TEST + 8);
    check(rxDrop, 1'b1);
    @(posedge clock);
    rxPktEnd <= 1'b1;
    rxActive <= 1'b0;
    k1State <= 1'b0;
    @(posedge clock);
    rxPktEnd <= 1'b0;
    repeat (2) @(negedge clock);
    check(fwdStart, 1'b0);
    // Awake link at 1 Gb/s forwards at once
    @(posedge clock);
    rxByteIn <= 1'b1;
    @(posedge clock);
    rxByteIn <= 1'b0;
    repeat (2) @(negedge clock);
    check(fwdStart, 1'b1);
    @(posedge clock);
    rxPktEnd <= 1'b1;
    fwdDone <= 1'b1;
    @(posedge clock);
    rxPktEnd <= 1'b0;
    fwdDone <= 1'b0;
    $display("test link done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
